// ### rtl/awru_top.sv
// Implicit weight and residual coefficient unpacker with APB registers
`timescale 1ns/10ps
module awru_top (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Indirect data words
	input wire logic ind_valid,
	input wire logic [31:0] ind_data,
	output logic ind_ready,
	// Downstream stall
	input wire logic out_ready,
	// Weight output
	output logic wt_valid,
	output logic [3:0] wt_block_mask,
	output logic [1:0] wt_comp,
	output logic [awru_pkg::WT_BITS-1:0] wt_list0,
	output logic [awru_pkg::WT_BITS-1:0] wt_list1,
	output logic [7:0] wt_offset_list0,
	output logic [7:0] wt_offset_list1,
	// Coefficient output
	output logic coef_valid,
	output logic [15:0] coef_value,
	output logic [5:0] coef_index,
	output logic block_last_flag,
	output logic mb_done
);
	import awru_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		awru_state_type state;
		logic [1:0] bipred_weight_mode;
		logic [5:0] motion_vector_size;
		logic [4:0] macroblock_type;
		logic transform_8x8;
		logic [15:0] len;
		logic [3:0] wcnt;
		logic [13:0] rem;
		logic err_mbz;
		logic err_idx;
		logic [15:0] coef_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic wt_valid;
		logic [3:0] wt_block_mask;
		logic [1:0] wt_comp;
		logic [WT_BITS-1:0] wt_list0;
		logic [WT_BITS-1:0] wt_list1;
		logic [7:0] wt_offset;
		logic coef_valid;
		logic [15:0] coef_value;
		logic [5:0] coef_index;
		logic block_last_flag;
		logic mb_done;
	} awru_top_type;

	awru_top_type r, next_r;
	logic go_wr, take, take_w, take_c, slot_free;
	logic [31:0] w;
	logic [WT_BITS-1:0] l0, l1;
	logic [5:0] new_mvs, idx_limit;
	logic needs_weight;

	awru_stream_if #(.WIDTH(32)) fifo_out ();

	awru_fifo #(.WIDTH(32), .DEPTH(4)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(ind_valid),
		.in_data(ind_data),
		.in_ready(ind_ready),
		.drain(fifo_out.src)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_r = r;
		next_r.mb_done = 1'b0;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		next_r.wt_offset = OFFSET_ZERO;
		if (r.wt_valid && out_ready) begin
			next_r.wt_valid = 1'b0;
		end
		if (r.coef_valid && out_ready) begin
			next_r.coef_valid = 1'b0;
		end
		// APB setup phase: decode and prepare the answer
		if (psel && !penable) begin
			next_r.pready = 1'b1;
			next_r.prdata = '0;
			if (paddr == CMD_ADDR) begin
				next_r.prdata[CMD_MODE_LSB +: 2] = r.bipred_weight_mode;
				next_r.prdata[CMD_MVS_LSB +: 6] = r.motion_vector_size;
				next_r.prdata[CMD_MBT_LSB +: 5] = r.macroblock_type;
				next_r.prdata[CMD_T8_BIT] = r.transform_8x8;
			end else if (paddr == LEN_ADDR) begin
				next_r.prdata[15:0] = r.len;
			end else if (paddr == STAT_ADDR) begin
				next_r.prdata[STAT_BUSY_BIT] = (r.state != ST_IDLE);
				next_r.prdata[STAT_MBZ_BIT] = r.err_mbz;
				next_r.prdata[STAT_IDX_BIT] = r.err_idx;
				next_r.prdata[STAT_CNT_LSB +: 16] = r.coef_cnt;
			end else begin
				next_r.pslverr = 1'b1;
			end
		end
		// APB access phase: writes take effect, to command and length only while idle
		new_mvs = pwdata[CMD_MVS_LSB +: 6];
		needs_weight = (new_mvs == MVS_ONE) || (new_mvs == MVS_8) ||
			(new_mvs == MVS_16) || (new_mvs == MVS_32);
		go_wr = psel && penable && r.pready && pwrite && (paddr == CMD_ADDR) &&
			pwdata[CMD_GO_BIT] && (r.state == ST_IDLE);
		if (psel && penable && r.pready && pwrite && (r.state == ST_IDLE)) begin
			if (paddr == CMD_ADDR) begin
				next_r.bipred_weight_mode = pwdata[CMD_MODE_LSB +: 2];
				next_r.motion_vector_size = new_mvs;
				next_r.macroblock_type = pwdata[CMD_MBT_LSB +: 5];
				next_r.transform_8x8 = pwdata[CMD_T8_BIT];
			end else if (paddr == LEN_ADDR) begin
				next_r.len = pwdata[15:0];
			end
		end
		if (psel && penable && r.pready && pwrite && (paddr == STAT_ADDR)) begin
			if (pwdata[STAT_MBZ_BIT]) begin
				next_r.err_mbz = 1'b0;
			end
			if (pwdata[STAT_IDX_BIT]) begin
				next_r.err_idx = 1'b0;
			end
		end
		if (go_wr) begin
			next_r.wcnt = '0;
			next_r.coef_cnt = '0;
			next_r.rem = r.len[15:2];
			if (needs_weight) begin
				next_r.state = ST_WEIGHT;
			end else if (r.len[15:2] != '0) begin
				next_r.state = ST_RESID;
			end else begin
				next_r.mb_done = 1'b1;
			end
		end
		// Word consumption, stalled while an output is held
		w = fifo_out.data;
		slot_free = (!r.wt_valid || out_ready) && (!r.coef_valid || out_ready);
		take = fifo_out.valid && slot_free && (r.state != ST_IDLE);
		take_w = take && (r.state == ST_WEIGHT) && (r.wcnt[1:0] != GROUP_LAST) &&
			(r.bipred_weight_mode == IMPLICIT_MODE);
		take_c = take && (r.state == ST_RESID);
		l0 = w[WT_L0_LSB +: WT_BITS];
		l1 = w[WT_L1_LSB +: WT_BITS];
		if (r.motion_vector_size == MVS_ONE) begin
			if (r.macroblock_type == MBT_L0) begin
				l1 = l0;
			end else if (r.macroblock_type == MBT_L1) begin
				l0 = l1;
			end
		end
		idx_limit = r.transform_8x8 ? IDX_MAX_8X8 : IDX_MAX_4X4;
		if (take && (r.state == ST_WEIGHT)) begin
			if (r.wcnt[1:0] == GROUP_LAST) begin
				if (w != '0) begin
					next_r.err_mbz = 1'b1;
				end
			end else if ((r.bipred_weight_mode == IMPLICIT_MODE) &&
				((w[15:9] != {7{w[8]}}) || (w[31:25] != {7{w[24]}}))) begin
				next_r.err_mbz = 1'b1;
			end
			if (take_w) begin
				next_r.wt_valid = 1'b1;
				next_r.wt_comp = r.wcnt[1:0];
				next_r.wt_list0 = l0;
				next_r.wt_list1 = l1;
				if (r.motion_vector_size == MVS_ONE) begin
					next_r.wt_block_mask = 4'hF;
				end else begin
					next_r.wt_block_mask = 4'h1 << r.wcnt[3:2];
				end
			end
			if (r.wcnt == ((r.motion_vector_size == MVS_ONE) ? WCNT_LAST_ONE : WCNT_LAST_FOUR)) begin
				next_r.wcnt = '0;
				if (r.rem != '0) begin
					next_r.state = ST_RESID;
				end else begin
					next_r.state = ST_IDLE;
					next_r.mb_done = 1'b1;
				end
			end else begin
				next_r.wcnt = r.wcnt + 4'h1;
			end
		end
		if (take_c) begin
			next_r.coef_valid = 1'b1;
			next_r.coef_value = w[COEF_VAL_LSB +: 16];
			next_r.coef_index = w[COEF_IDX_LSB +: 6];
			next_r.block_last_flag = w[COEF_LAST_BIT];
			next_r.coef_cnt = r.coef_cnt + 16'h1;
			if (w[15:7] != '0) begin
				next_r.err_mbz = 1'b1;
			end
			if (w[COEF_IDX_LSB +: 6] > idx_limit) begin
				next_r.err_idx = 1'b1;
			end
			next_r.rem = r.rem - 14'h1;
			if (r.rem == 14'h1) begin
				next_r.state = ST_IDLE;
				next_r.mb_done = 1'b1;
			end
		end
	end

	assign fifo_out.ready = take;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '0;
			r.state <= ST_IDLE;
			r.len <= LEN_RESET;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign wt_valid = r.wt_valid;
	assign wt_block_mask = r.wt_block_mask;
	assign wt_comp = r.wt_comp;
	assign wt_list0 = r.wt_list0;
	assign wt_list1 = r.wt_list1;
	assign wt_offset_list0 = r.wt_offset;
	assign wt_offset_list1 = r.wt_offset;
	assign coef_valid = r.coef_valid;
	assign coef_value = r.coef_value;
	assign coef_index = r.coef_index;
	assign block_last_flag = r.block_last_flag;
	assign mb_done = r.mb_done;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_go_size0;
		go_wr && (new_mvs == MVS_NONE);
	endsequence

	sequence s_weight_word;
		take_w ##1 r.wt_valid;
	endsequence

	AST_IMPLICIT_ONLY: assert property (
		(take && (r.state == ST_WEIGHT) && (r.bipred_weight_mode != IMPLICIT_MODE)) |=>
			!r.wt_valid)
		else $error("Weight issued outside implicit mode");
	AST_ZERO_OFFSET: assert property (
		s_weight_word |-> (wt_offset_list0 == OFFSET_ZERO) && (wt_offset_list1 == OFFSET_ZERO))
		else $error("Non-zero offset with implicit weight");
	AST_WEIGHT_SLOT: assert property (
		(take_w && (r.motion_vector_size != MVS_ONE)) |=>
			(r.wt_list0 == $past(fifo_out.data[8:0])) && (r.wt_list1 == $past(fifo_out.data[24:16])))
		else $error("Weight not taken from its slot");
	AST_GROUP_MBZ: assert property (
		(take && (r.state == ST_WEIGHT) && (r.wcnt[1:0] == GROUP_LAST) && (fifo_out.data != '0))
			|=> r.err_mbz)
		else $error("Non-zero fourth group word not flagged");
	AST_COPY_L0: assert property (
		(take_w && (r.motion_vector_size == MVS_ONE) && (r.macroblock_type == MBT_L0)) |=>
			(r.wt_list1 == r.wt_list0) && (r.wt_block_mask == 4'hF))
		else $error("List-0 weight not copied to list 1");
	AST_COPY_L1: assert property (
		(take_w && (r.motion_vector_size == MVS_ONE) && (r.macroblock_type == MBT_L1)) |=>
			(r.wt_list0 == $past(fifo_out.data[24:16])))
		else $error("List-1 weight not copied to list 0");
	AST_BLOCK_MASK: assert property (
		(take_w && (r.motion_vector_size != MVS_ONE)) |=>
			(r.wt_block_mask == (4'h1 << $past(r.wcnt[3:2]))))
		else $error("Weight group steered to wrong block");
	AST_COEF_FIELDS: assert property (
		take_c |=> r.coef_valid && (r.coef_index == $past(fifo_out.data[6:1])) &&
			(r.block_last_flag == $past(fifo_out.data[0])))
		else $error("Coefficient fields misplaced");
	AST_RESID_MBZ: assert property (
		(take_c && (fifo_out.data[15:7] != '0)) |=> r.err_mbz)
		else $error("Reserved coefficient bits not flagged");
	AST_INDEX_RANGE: assert property (
		(take_c && !r.transform_8x8 && (fifo_out.data[6:1] > IDX_MAX_4X4)) |=> r.err_idx)
		else $error("Index beyond 4x4 range not flagged");
	AST_LEN_COUNT: assert property (
		(take_c && (r.rem == 14'h1)) |=> r.mb_done && (r.state == ST_IDLE))
		else $error("Macroblock did not end at its length");
	AST_NO_WEIGHT_SIZE0: assert property (
		s_go_size0 |=> (r.state != ST_WEIGHT) [*2])
		else $error("Weight block fetched for size 0");
endmodule

// ### rtl/awru_pkg.sv
// Shared constants and types of the weight and residual unpacker
package awru_pkg;
	// Register byte offsets
	localparam logic [11:0] CMD_ADDR = 12'h000;
	localparam logic [11:0] LEN_ADDR = 12'h004;
	localparam logic [11:0] STAT_ADDR = 12'h008;
	// Command register fields
	localparam int CMD_MODE_LSB = 0;
	localparam int CMD_MVS_LSB = 8;
	localparam int CMD_MBT_LSB = 16;
	localparam int CMD_T8_BIT = 24;
	localparam int CMD_GO_BIT = 31;
	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_MBZ_BIT = 1;
	localparam int STAT_IDX_BIT = 2;
	localparam int STAT_CNT_LSB = 16;
	// Weighting and partition codes
	localparam logic [1:0] IMPLICIT_MODE = 2'h2;
	localparam logic [5:0] MVS_NONE = 6'h00;
	localparam logic [5:0] MVS_ONE = 6'h02;
	localparam logic [5:0] MVS_8 = 6'h08;
	localparam logic [5:0] MVS_16 = 6'h10;
	localparam logic [5:0] MVS_32 = 6'h20;
	localparam logic [4:0] MBT_L0 = 5'h01;
	localparam logic [4:0] MBT_L1 = 5'h02;
	localparam logic [4:0] MBT_BI = 5'h03;
	// Weight group layout
	localparam logic [1:0] GROUP_LAST = 2'h3;
	localparam logic [3:0] WCNT_LAST_ONE = 4'h3;
	localparam logic [3:0] WCNT_LAST_FOUR = 4'hF;
	localparam int WT_L0_LSB = 0;
	localparam int WT_L1_LSB = 16;
	localparam int WT_BITS = 9;
	// Coefficient unit layout
	localparam int COEF_VAL_LSB = 16;
	localparam int COEF_IDX_LSB = 1;
	localparam int COEF_LAST_BIT = 0;
	localparam logic [5:0] IDX_MAX_4X4 = 6'h0F;
	localparam logic [5:0] IDX_MAX_8X8 = 6'h3F;
	// Reset values
	localparam logic [15:0] LEN_RESET = 16'h0000;
	localparam logic [7:0] OFFSET_ZERO = 8'h00;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WEIGHT = 2'b01,
		ST_RESID = 2'b10
	} awru_state_type;
endpackage

// ### rtl/awru_stream_if.sv
// Valid and ready word stream between the buffer and the unpacker
`timescale 1ns/10ps
interface awru_stream_if #(parameter int WIDTH = 32);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### rtl/awru_fifo.sv
// Word FIFO in front of the unpacker
`timescale 1ns/10ps
module awru_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	awru_stream_if.src drain
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
		logic space;
	} awru_fifo_type;

	awru_fifo_type r, next_r;
	logic push, pop;

	always_comb begin
		next_r = r;
		push = in_valid && r.space;
		pop = drain.ready && (r.cnt != '0);
		if (push) begin
			next_r.mem[r.wr] = in_data;
			next_r.wr = (r.wr == LAST) ? '0 : r.wr + 1'b1;
		end
		if (pop) begin
			next_r.rd = (r.rd == LAST) ? '0 : r.rd + 1'b1;
		end
		next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		next_r.space = (next_r.cnt != FULL);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '0;
			r.space <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign in_ready = r.space;
	assign drain.valid = (r.cnt != '0);
	assign drain.data = r.mem[r.rd];

	AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (sys_rst) r.cnt <= FULL)
		else $error("FIFO count above depth");
endmodule

// ### sim/awru_buf_model.sv
// Indirect data buffer model feeding words to the unpacker
`timescale 1ns/10ps
module awru_buf_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Slow answer control
	input wire logic stall,
	// Word stream
	output logic ind_valid,
	output logic [31:0] ind_data,
	input wire logic ind_ready
);
	logic [31:0] q[$];
	// Words are queued whole, weight block first, then coefficients
	task push(input logic [31:0] w);
		q.push_back(w);
	endtask
	always @(posedge clk) begin
		if (sys_rst) begin
			ind_valid <= 1'b0;
			ind_data <= 32'h0;
		end else if (ind_valid && !ind_ready) begin
			ind_valid <= 1'b1;
		end else if (q.size() > 0 && !stall) begin
			ind_valid <= 1'b1;
			ind_data <= q.pop_front();
		end else begin
			ind_valid <= 1'b0;
			ind_data <= ~ind_data;
		end
	end
endmodule

// ### sim/awru_tb_top.sv
// Self-checking bench of the weight and residual unpacker
`timescale 1ns/10ps
module awru_tb_top;
	import awru_pkg::*;
	logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, out_ready = 1, stall = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, ind_data, rd;
	logic pready, pslverr, ind_valid, ind_ready, wt_valid, coef_valid, block_last_flag, mb_done, er;
	logic [3:0] wt_block_mask;
	logic [1:0] wt_comp;
	logic [8:0] wt_list0, wt_list1;
	logic [7:0] wt_offset_list0, wt_offset_list1;
	logic [15:0] coef_value;
	logic [5:0] coef_index;
	logic [39:0] wq[$];
	logic [22:0] cq[$];
	int errors = 0, tests_run = 0, dones = 0;
	always #2 clk = ~clk;
	awru_top awru_top_i (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .ind_valid, .ind_data, .ind_ready, .out_ready, .wt_valid,
		.wt_block_mask, .wt_comp, .wt_list0, .wt_list1, .wt_offset_list0, .wt_offset_list1,
		.coef_valid, .coef_value, .coef_index, .block_last_flag, .mb_done);
	awru_buf_model awru_buf_model_i (.clk, .sys_rst, .stall, .ind_valid, .ind_data, .ind_ready);
	always @(posedge clk) begin
		if (wt_valid === 1'b1 && out_ready) wq.push_back({wt_block_mask, wt_comp,
			wt_offset_list0, wt_offset_list1, wt_list1, wt_list0});
		if (coef_valid === 1'b1 && out_ready) cq.push_back({coef_value, coef_index, block_last_flag});
		if (mb_done === 1'b1) dones++;
	end
	////////////////////////////////////////////////////////////////
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask
	function automatic logic [31:0] ww(input logic [8:0] l1, input logic [8:0] l0);
		return {{7{l1[8]}}, l1, {7{l0[8]}}, l0};
	endfunction
	task automatic mb(input logic [1:0] md, input logic [5:0] mv, input logic [4:0] mt,
		input logic t8, input logic [15:0] ln, input bit stl);
		int n;
		n = dones;
		apb(1, LEN_ADDR, {16'h0, ln});
		apb(1, CMD_ADDR, {1'b1, 6'h0, t8, 3'h0, mt, 2'h0, mv, 6'h0, md});
		if (stl) begin
			out_ready <= 0;
			repeat (20) @(posedge clk);
			chk(ind_ready, 0);
			out_ready <= 1;
		end
		for (int i = 0; i < 300 && dones == n; i++) @(posedge clk);
		chk(dones, n + 1);
	endtask
	////////////////////////////////////////////////////////////////
	task t_size2;
		logic [8:0] a, b;
		for (int t = 1; t <= 3; t++) begin
			for (int c = 0; c < 3; c++) awru_buf_model_i.push(ww(9'h1F0 - c, 9'h020 + c));
			awru_buf_model_i.push(32'h0);
			mb(IMPLICIT_MODE, MVS_ONE, t, 0, 0, 0);
			for (int c = 0; c < 3; c++) begin
				a = 9'h020 + c;
				b = 9'h1F0 - c;
				if (t == 1) b = a;
				if (t == 2) a = b;
				chk(wq.pop_front(), {4'hF, 2'(c), 16'h0, b, a});
			end
		end
	endtask
	task t_size_n;
		for (int k = 0; k < 3; k++) begin
			for (int g = 0; g < 4; g++) begin
				for (int c = 0; c < 3; c++) awru_buf_model_i.push(ww(9'h100 + g, 8 * g + c));
				awru_buf_model_i.push(32'h0);
			end
			mb(IMPLICIT_MODE, 6'h08 << k, MBT_BI, 0, 0, k == 0);
			for (int g = 0; g < 12; g++)
				chk(wq.pop_front(), {4'h1 << (g / 3), 2'(g % 3), 16'h0, 9'(9'h100 + g / 3),
					9'(8 * (g / 3) + g % 3)});
		end
	endtask
	task t_mode;
		for (int c = 0; c < 3; c++) awru_buf_model_i.push(32'h0540_0320);
		awru_buf_model_i.push(32'h0);
		mb(2'h1, MVS_ONE, MBT_BI, 0, 0, 0);
		chk(wq.size(), 0);
		apb(0, STAT_ADDR, 0);
		chk(rd[2:1], 2'b00);
		mb(IMPLICIT_MODE, MVS_NONE, MBT_L0, 0, 0, 0);
		chk(wq.size(), 0);
	endtask
	task t_coef;
		awru_buf_model_i.push({16'hFFF6, 9'h0, 6'd15, 1'b1});
		awru_buf_model_i.push({16'h0123, 9'h0, 6'd0, 1'b0});
		awru_buf_model_i.push({16'h7FFF, 9'h0, 6'd63, 1'b1});
		stall <= 1;
		fork begin repeat (12) @(posedge clk); stall <= 0; end join_none
		mb(IMPLICIT_MODE, MVS_NONE, MBT_L0, 1, 12, 0);
		chk(cq.pop_front(), {16'hFFF6, 6'd15, 1'b1});
		chk(cq.pop_front(), {16'h0123, 6'd0, 1'b0});
		chk(cq.pop_front(), {16'h7FFF, 6'd63, 1'b1});
		apb(0, STAT_ADDR, 0);
		chk({rd[31:16], rd[2:0]}, {16'd3, 3'b000});
		awru_buf_model_i.push({16'h0005, 9'h0, 6'd16, 1'b1});
		awru_buf_model_i.push({16'h0006, 9'h001, 6'd2, 1'b0});
		mb(IMPLICIT_MODE, MVS_NONE, MBT_L0, 0, 8, 0);
		cq.delete();
		apb(0, STAT_ADDR, 0);
		chk(rd[2:1], 2'b11);
		apb(1, STAT_ADDR, 32'h6);
		apb(0, STAT_ADDR, 0);
		chk(rd[2:1], 2'b00);
		apb(0, 12'h00C, 0);
		chk({er, rd}, {1'b1, 32'h0});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		chk({ind_ready, wt_valid, coef_valid}, 3'b100);
		t_size2;
		t_size_n;
		t_mode;
		t_coef;
		close_out;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out;
	end
endmodule
